//--- verilog/mssr_pkg.sv
// Constants and types for the status and result register group
package mssr_pkg;

    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned SLOT_N = 4;
    localparam int unsigned RAW_N = 6;
    localparam int unsigned SRC_W = 3;
    localparam int unsigned TABLE_W = 2;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0107;
    localparam logic [ADDR_W-1:0] ADDR_TEMP = 16'h0110;
    localparam logic [ADDR_W-1:0] ADDR_FIELD0 = 16'h0111;
    localparam logic [ADDR_W-1:0] ADDR_FIELD1 = 16'h0112;
    localparam logic [ADDR_W-1:0] ADDR_FIELD2 = 16'h0113;
    localparam logic [ADDR_W-1:0] ADDR_FIELD3 = 16'h0114;
    localparam logic [ADDR_W-1:0] ADDR_LIN_ANGLE = 16'h0122;

    // Status word bit positions
    localparam int unsigned BIT_READY = 15;
    localparam int unsigned BIT_LOST = 14;
    localparam int unsigned BIT_CORR = 13;
    localparam int unsigned BIT_NORM = 12;
    localparam int unsigned BIT_SENS = 11;
    localparam int unsigned BIT_RANGE = 10;
    localparam int unsigned BIT_HIST = 9;
    localparam int unsigned BIT_CALC = 8;
    localparam int unsigned BIT_ORIENT = 1;
    localparam int unsigned BIT_NVM = 0;

    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] UNMAPPED_WORD = 16'h0000;

    // Raw component index per result slot, one row per table choice.
    // Raw order: x0, y0, z0, x1, y1, z1
    localparam logic [3:0][SLOT_N-1:0][SRC_W-1:0] TABLE_SRC = '{
        '{3'h5, 3'h2, 3'h4, 3'h1},
        '{3'h4, 3'h1, 3'h3, 3'h0},
        '{3'h2, 3'h5, 3'h1, 3'h4},
        '{3'h4, 3'h1, 3'h3, 3'h0}
    };

    typedef enum logic [0:0] {
        MSSR_LINK_IDLE = 1'b0,
        MSSR_LINK_WAIT = 1'b1
    } mssr_link_state_t;

endpackage

//--- verilog/mssr_xfer_if.sv
// Read request and answer carrier between link crossing and register core
`timescale 1ns/10ps
interface mssr_xfer_if;
    logic req_pulse;
    logic [mssr_pkg::ADDR_W-1:0] req_addr;
    logic rsp_pulse;
    logic [mssr_pkg::WORD_W-1:0] rsp_data;

    modport core (
        input req_pulse,
        input req_addr,
        output rsp_pulse,
        output rsp_data
    );

    modport link (
        output req_pulse,
        output req_addr,
        input rsp_pulse,
        input rsp_data
    );
endinterface

//--- verilog/mssr_link_cdc.sv
// Toggle handshake carrying register reads from the link clock to the core
`timescale 1ns/10ps
module mssr_link_cdc (
    input wire logic core_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_b_i,
    input wire logic rd_req_i,
    input wire logic [mssr_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [mssr_pkg::WORD_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_busy_o,
    mssr_xfer_if.link xf
);
    import mssr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Link domain
    mssr_link_state_t state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [WORD_W-1:0] data_q, data_d;
    logic valid_q, valid_d;
    logic req_tgl_q, req_tgl_d;
    logic ack_s1_q, ack_s2_q, ack_s3_q;
    logic ack_edge;
    // Core-domain toggle, declared here as the link side samples it
    logic ack_tgl_q, ack_tgl_d;

    assign ack_edge = ack_s2_q ^ ack_s3_q;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        data_d = data_q;
        valid_d = 1'b0;
        req_tgl_d = req_tgl_q;
        unique case (state_q)
            MSSR_LINK_IDLE: begin
                if (rd_req_i) begin
                    addr_d = rd_addr_i;
                    req_tgl_d = ~req_tgl_q;
                    state_d = MSSR_LINK_WAIT;
                end
            end
            MSSR_LINK_WAIT: begin
                if (ack_edge) begin
                    data_d = xf.rsp_data;
                    valid_d = 1'b1;
                    state_d = MSSR_LINK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= MSSR_LINK_IDLE;
            addr_q <= '0;
            data_q <= '0;
            valid_q <= 1'b0;
            req_tgl_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            data_q <= data_d;
            valid_q <= valid_d;
            req_tgl_q <= req_tgl_d;
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    assign rd_data_o = data_q;
    assign rd_valid_o = valid_q;
    assign rd_busy_o = (state_q == MSSR_LINK_WAIT);

    ////////////////////////////////////////////////////////////////////
    // Core domain; address is held still until the answer returns
    logic req_s1_q, req_s2_q, req_s3_q;

    always_comb begin
        ack_tgl_d = ack_tgl_q ^ xf.rsp_pulse;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            ack_tgl_q <= ack_tgl_d;
        end
    end

    assign xf.req_pulse = req_s2_q ^ req_s3_q;
    assign xf.req_addr = addr_q;

endmodule // mssr_link_cdc

//--- verilog/mssr_status_results.sv
// Status word and measurement result registers with link read port
`timescale 1ns/10ps
module mssr_status_results (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic rd_req_i,
    input wire logic [mssr_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [mssr_pkg::WORD_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_busy_o,
    input wire logic meas_start_i,
    input wire logic meas_done_i,
    input wire logic [mssr_pkg::WORD_W-1:0] field_mag_i,
    input wire logic [mssr_pkg::WORD_W-1:0] lost_thresh_i,
    input wire logic corr_ovfl_i,
    input wire logic norm_ovfl_i,
    input wire logic sens_ovfl_i,
    input wire logic range_ovfl_i,
    input wire logic hist_fail_i,
    input wire logic [mssr_pkg::WORD_W-1:0] temp_i,
    input wire logic [mssr_pkg::RAW_N-1:0][mssr_pkg::WORD_W-1:0] raw_field_i,
    input wire logic [mssr_pkg::TABLE_W-1:0] component_table_choice_i,
    input wire logic magnet_orientation_i,
    input wire logic nvm_write_busy_i,
    output logic meas_ready_o
);
    import mssr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [WORD_W-1:0] slot_pick(
        input logic [TABLE_W-1:0] choice,
        input int unsigned slot,
        input logic [RAW_N-1:0][WORD_W-1:0] raw
    );
        logic [SRC_W-1:0] src;
        src = TABLE_SRC[choice][slot];
        if (src < SRC_W'(RAW_N)) begin
            slot_pick = raw[src];
        end else begin
            slot_pick = RESULT_RESET;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link crossing

    mssr_xfer_if xf ();

    mssr_link_cdc u_link_cdc (
        .core_clk_i(core_clk_i),
        .link_clk_i(link_clk_i),
        .rst_b_i(rst_b_i),
        .rd_req_i(rd_req_i),
        .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .rd_busy_o(rd_busy_o),
        .xf(xf.link)
    );

    ////////////////////////////////////////////////////////////////////
    // Status word

    logic [WORD_W-1:0] status_q, status_d;
    logic ready_clear;
    logic fault_any;

    // Ready drops on an angle read or when a new cycle starts
    assign ready_clear = (xf.req_pulse && (xf.req_addr == ADDR_LIN_ANGLE))
                         || meas_start_i;

    assign fault_any = range_ovfl_i | hist_fail_i | norm_ovfl_i
                       | sens_ovfl_i;

    always_comb begin
        status_d = status_q;
        status_d[BIT_ORIENT] = magnet_orientation_i;
        status_d[BIT_NVM] = ~nvm_write_busy_i;
        if (ready_clear) begin
            status_d[BIT_READY] = 1'b0;
        end
        // Completion beats a clear in the same cycle
        if (meas_done_i) begin
            status_d[BIT_READY] = 1'b1;
            status_d[BIT_LOST] = (field_mag_i < lost_thresh_i);
            status_d[BIT_CORR] = corr_ovfl_i;
            status_d[BIT_NORM] = norm_ovfl_i;
            status_d[BIT_SENS] = sens_ovfl_i;
            status_d[BIT_RANGE] = range_ovfl_i;
            status_d[BIT_HIST] = hist_fail_i;
            status_d[BIT_CALC] = fault_any;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    assign meas_ready_o = status_q[BIT_READY];

    ////////////////////////////////////////////////////////////////////
    // Result registers

    logic [WORD_W-1:0] temp_q, temp_d;
    logic [SLOT_N-1:0][WORD_W-1:0] field_q, field_d;

    // Stored as delivered: signed counts, scale is the converter's
    always_comb begin
        temp_d = temp_q;
        if (meas_done_i) begin
            temp_d = temp_i;
        end
    end

    generate
        for (genvar s = 0; s < SLOT_N; s++) begin : g_slot
            always_comb begin
                field_d[s] = field_q[s];
                if (meas_done_i) begin
                    field_d[s] = slot_pick(component_table_choice_i,
                                           s, raw_field_i);
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_q <= RESULT_RESET;
            field_q <= '0;
        end else begin
            temp_q <= temp_d;
            field_q <= field_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read answer; a read in a completion cycle sees the old set

    logic [WORD_W-1:0] rsp_data_q, rsp_data_d;
    logic rsp_pulse_q, rsp_pulse_d;

    always_comb begin
        rsp_data_d = rsp_data_q;
        rsp_pulse_d = 1'b0;
        if (xf.req_pulse) begin
            rsp_pulse_d = 1'b1;
            unique case (xf.req_addr)
                ADDR_STATUS: rsp_data_d = status_q;
                ADDR_TEMP: rsp_data_d = temp_q;
                ADDR_FIELD0: rsp_data_d = field_q[0];
                ADDR_FIELD1: rsp_data_d = field_q[1];
                ADDR_FIELD2: rsp_data_d = field_q[2];
                ADDR_FIELD3: rsp_data_d = field_q[3];
                default: rsp_data_d = UNMAPPED_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_data_q <= UNMAPPED_WORD;
            rsp_pulse_q <= 1'b0;
        end else begin
            rsp_data_q <= rsp_data_d;
            rsp_pulse_q <= rsp_pulse_d;
        end
    end

    assign xf.rsp_data = rsp_data_q;
    assign xf.rsp_pulse = rsp_pulse_q;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_ready_set;
        meas_done_i |=> status_q[BIT_READY] && meas_ready_o;
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("ready not set after completion");

    property p_ready_pin;
        xf.req_pulse && xf.req_addr == ADDR_STATUS
            |=> xf.rsp_data[BIT_READY] == $past(meas_ready_o);
    endproperty
    a_ready_pin: assert property (p_ready_pin)
        else $error("ready pin and status bit differ");

    property p_lost;
        meas_done_i |=> status_q[BIT_LOST]
            == ($past(field_mag_i) < $past(lost_thresh_i));
    endproperty
    a_lost: assert property (p_lost)
        else $error("field lost flag wrong");

    property p_corr;
        meas_done_i |=> status_q[BIT_CORR] == $past(corr_ovfl_i);
    endproperty
    a_corr: assert property (p_corr)
        else $error("angle correction overflow flag wrong");

    property p_sens_norm;
        meas_done_i |=> status_q[BIT_SENS] == $past(sens_ovfl_i)
            && status_q[BIT_NORM] == $past(norm_ovfl_i);
    endproperty
    a_sens_norm: assert property (p_sens_norm)
        else $error("overflow flags wrong");

    property p_rng_hist;
        meas_done_i |=> status_q[BIT_RANGE] == $past(range_ovfl_i)
            && status_q[BIT_HIST] == $past(hist_fail_i);
    endproperty
    a_rng_hist: assert property (p_rng_hist)
        else $error("converter warning flags wrong");

    property p_calc;
        status_q[BIT_CALC] == (status_q[BIT_RANGE] | status_q[BIT_HIST]
            | status_q[BIT_NORM] | status_q[BIT_SENS]);
    endproperty
    a_calc: assert property (p_calc)
        else $error("calculation fault is not the OR of its flags");

    property p_orient;
        ##1 status_q[BIT_ORIENT] == $past(magnet_orientation_i);
    endproperty
    a_orient: assert property (p_orient)
        else $error("orientation bit wrong");

    property p_nvm;
        $rose(nvm_write_busy_i) |=> !status_q[BIT_NVM];
    endproperty
    a_nvm: assert property (p_nvm)
        else $error("nvm done bit high during write");

    property p_temp;
        meas_done_i |=> temp_q == $past(temp_i);
    endproperty
    a_temp: assert property (p_temp)
        else $error("temperature not captured");

    property p_clear;
        xf.req_pulse && xf.req_addr == ADDR_LIN_ANGLE && !meas_done_i
            |=> !meas_ready_o;
    endproperty
    a_clear: assert property (p_clear)
        else $error("ready not cleared by angle read");

    property p_hold;
        !meas_done_i |=> $stable(temp_q) && $stable(field_q)
            && $stable(status_q[BIT_LOST:BIT_CALC]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("results changed outside completion");

    property p_reserved;
        status_q[BIT_CALC-1:BIT_ORIENT+1] == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits not zero");

    property p_start_clear;
        meas_start_i && !meas_done_i |=> !meas_ready_o;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("ready not cleared by measurement start");

    property p_done_wins;
        ready_clear && meas_done_i |=> meas_ready_o;
    endproperty
    a_done_wins: assert property (p_done_wins)
        else $error("clear beat completion in the same cycle");

    property p_ready_rise;
        $rose(meas_ready_o) |-> $past(meas_done_i);
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("ready rose without completion");

    property p_nvm_done;
        $fell(nvm_write_busy_i) |=> status_q[BIT_NVM];
    endproperty
    a_nvm_done: assert property (p_nvm_done)
        else $error("nvm done bit low after write");

    property p_rsp_pulse;
        xf.req_pulse |=> xf.rsp_pulse;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("read request not answered");

    property p_rsp_status;
        xf.req_pulse && xf.req_addr == ADDR_STATUS
            |=> xf.rsp_data == $past(status_q);
    endproperty
    a_rsp_status: assert property (p_rsp_status)
        else $error("status read answer wrong");

    property p_rsp_temp;
        xf.req_pulse && xf.req_addr == ADDR_TEMP
            |=> xf.rsp_data == $past(temp_q);
    endproperty
    a_rsp_temp: assert property (p_rsp_temp)
        else $error("temperature read answer wrong");

    property p_rsp_angle;
        xf.req_pulse && xf.req_addr == ADDR_LIN_ANGLE
            |=> xf.rsp_data == UNMAPPED_WORD;
    endproperty
    a_rsp_angle: assert property (p_rsp_angle)
        else $error("angle address read not zero");

    // Slot contents follow the table row chosen at completion
    generate
        for (genvar s = 0; s < SLOT_N; s++) begin : g_slot_chk
            property p_slot;
                @(posedge core_clk_i) disable iff (!rst_b_i)
                meas_done_i |=> field_q[s] == $past(
                    raw_field_i[TABLE_SRC[component_table_choice_i][s]]);
            endproperty
            a_slot: assert property (p_slot)
                else $error("field slot not filled from table");
        end
    endgenerate

endmodule // mssr_status_results

//--- tb/mssr_host_model.sv
// Host-side reader of the link register port
`timescale 1ns/10ps
module mssr_host_model (
    input wire logic link_clk_i,
    output logic rd_req_o,
    output logic [mssr_pkg::ADDR_W-1:0] rd_addr_o,
    input wire logic [mssr_pkg::WORD_W-1:0] rd_data_i,
    input wire logic rd_valid_i,
    input wire logic rd_busy_i
);
    import mssr_pkg::*;
    logic discard;
    initial begin
        rd_req_o = 1'b0;
        rd_addr_o = 16'h0000;
        discard = 1'b0;
    end
    // Request held for the one edge that takes it; addr garbled after
    task automatic rd(input logic [ADDR_W-1:0] addr,
                      output logic [WORD_W-1:0] data, output bit ok);
        int n;
        ok = 1'b0;
        data = 16'h0000;
        n = 0;
        @(negedge link_clk_i);
        while (rd_busy_i !== 1'b0 && n < 40) begin
            @(negedge link_clk_i);
            n++;
        end
        rd_addr_o = addr;
        rd_req_o = 1'b1;
        @(negedge link_clk_i);
        rd_req_o = 1'b0;
        rd_addr_o = ~addr;
        for (n = 0; n < 40 && !ok; n++) begin
            @(negedge link_clk_i);
            if (rd_valid_i === 1'b1) begin
                data = rd_data_i;
                ok = 1'b1;
            end
        end
        // Faulty cycle: results of this cycle are not to be used
        if (ok && addr == ADDR_STATUS) begin
            discard = data[BIT_CALC];
        end
    endtask
endmodule // mssr_host_model

//--- tb/testbench.sv
// Self-checking bench for the status and result register group
`timescale 1ns/10ps
module testbench;
    import mssr_pkg::*;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rd_req;
    logic rd_valid;
    logic rd_busy;
    logic meas_ready;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_W-1:0] rd_data;
    logic meas_start = 1'b0;
    logic meas_done = 1'b0;
    logic [WORD_W-1:0] mag = 16'h0000;
    logic [WORD_W-1:0] thr = 16'h0100;
    logic [4:0] ovf = 5'h00;
    logic [WORD_W-1:0] temp = 16'h0000;
    logic [RAW_N-1:0][WORD_W-1:0] raw = '0;
    logic [TABLE_W-1:0] choice = 2'h0;
    logic orient = 1'b0;
    logic nvm_busy = 1'b0;
    int n_fail = 0;
    int n_checks = 0;

    always #4 core_clk = ~core_clk;
    always #3 link_clk = ~link_clk;

    mssr_status_results u_dut (
        .core_clk_i(core_clk),
        .rst_b_i(rst_b),
        .link_clk_i(link_clk),
        .rd_req_i(rd_req),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data),
        .rd_valid_o(rd_valid),
        .rd_busy_o(rd_busy),
        .meas_start_i(meas_start),
        .meas_done_i(meas_done),
        .field_mag_i(mag),
        .lost_thresh_i(thr),
        .corr_ovfl_i(ovf[4]),
        .norm_ovfl_i(ovf[3]),
        .sens_ovfl_i(ovf[2]),
        .range_ovfl_i(ovf[1]),
        .hist_fail_i(ovf[0]),
        .temp_i(temp),
        .raw_field_i(raw),
        .component_table_choice_i(choice),
        .magnet_orientation_i(orient),
        .nvm_write_busy_i(nvm_busy),
        .meas_ready_o(meas_ready)
    );

    mssr_host_model u_host (
        .link_clk_i(link_clk),
        .rd_req_o(rd_req),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_valid_i(rd_valid),
        .rd_busy_i(rd_busy)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [WORD_W-1:0] exp,
                         input logic [WORD_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic read_chk(input string what, input logic [ADDR_W-1:0] a,
                            input logic [WORD_W-1:0] exp);
        logic [WORD_W-1:0] d;
        bit ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            n_fail++;
            wrap_up();
        end else begin
            check(what, exp, d);
        end
    endtask

    // Bits 13..9 follow the order of ovf, so the word is built directly
    function automatic logic [WORD_W-1:0] status(input logic lost,
                                                 input logic [4:0] f);
        return {1'b1, lost, f, |f[3:0], 6'h00, orient, ~nvm_busy};
    endfunction

    task automatic measure(input logic [WORD_W-1:0] m, input logic [4:0] f,
                           input logic [TABLE_W-1:0] c);
        @(negedge core_clk);
        mag = m;
        ovf = f;
        choice = c;
        meas_done = 1'b1;
        @(negedge core_clk);
        meas_done = 1'b0;
        check("ready after done", 16'h0001, {15'h0000, meas_ready});
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("ready at reset", 16'h0000, {15'h0000, meas_ready});
        read_chk("status at reset", ADDR_STATUS, 16'h0001);
        read_chk("temp at reset", ADDR_TEMP, 16'h0000);
        $display("Test reset done");
    endtask

    // Each flag alone, then magnitude just under and at the threshold
    task automatic t_flags();
        logic [4:0] f;
        logic [WORD_W-1:0] m;
        for (int i = 0; i < 7; i++) begin
            f = (i < 5) ? (5'h10 >> i) : 5'h00;
            m = (i == 5) ? 16'h00ff : ((i == 6) ? 16'h0100 : 16'h0200);
            measure(m, f, 2'h0);
            read_chk("status", ADDR_STATUS, status(i == 5, f));
            check("discard", {15'h0000, |f[3:0]}, {15'h0000, u_host.discard});
        end
        measure(16'h0200, 5'h1f, 2'h0);
        read_chk("status all", ADDR_STATUS, status(1'b0, 5'h1f));
        @(negedge core_clk);
        orient = 1'b1;
        nvm_busy = 1'b1;
        repeat (2) @(negedge core_clk);
        read_chk("live bits", ADDR_STATUS, 16'hbf02);
        nvm_busy = 1'b0;
        $display("Test flags done");
    endtask

    // Inputs change after capture; reads must still see the snapshot
    task automatic t_results();
        logic [RAW_N-1:0][WORD_W-1:0] r;
        logic [WORD_W-1:0] t;
        for (int c = 0; c < 4; c++) begin
            for (int k = 0; k < RAW_N; k++) begin
                raw[k] = {4'h8, 2'(c), 6'h00, 4'(k)};
            end
            temp = 16'hfc18 + 16'(c);
            measure(16'h0200, 5'h00, 2'(c));
            r = raw;
            t = temp;
            raw = ~raw;
            temp = ~temp;
            read_chk("temp", ADDR_TEMP, t);
            for (int s = 0; s < SLOT_N; s++) begin
                read_chk("slot", ADDR_FIELD0 + 16'(s), r[TABLE_SRC[c][s]]);
            end
        end
        $display("Test results done");
    endtask

    task automatic t_clear();
        int n;
        measure(16'h0200, 5'h00, 2'h0);
        read_chk("angle read", ADDR_LIN_ANGLE, 16'h0000);
        for (n = 0; n < 20 && meas_ready !== 1'b0; n++) begin
            @(negedge core_clk);
        end
        check("ready after angle", 16'h0000, {15'h0000, meas_ready});
        read_chk("status cleared", ADDR_STATUS, 16'h0003);
        read_chk("unmapped", 16'h0108, 16'h0000);
        measure(16'h0200, 5'h00, 2'h0);
        meas_start = 1'b1;
        @(negedge core_clk);
        meas_start = 1'b0;
        check("ready after start", 16'h0000, {15'h0000, meas_ready});
        // Start and completion together: completion wins
        meas_start = 1'b1;
        measure(16'h0200, 5'h00, 2'h0);
        meas_start = 1'b0;
        $display("Test clear done");
    endtask

    initial begin
        repeat (4) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge link_clk);
        t_reset();
        t_flags();
        t_results();
        t_clear();
        wrap_up();
    end
endmodule // testbench
